// ==== src/parallel_master_slave_port.sv ====
// parallel port top: addressable slave buffers and the master bus sequencer
`timescale 1ns/1ps
`default_nettype none
`include "pmp_consts.svh"

module parallel_master_slave_port (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic module_enable,
	input wire logic [1:0] mode_sel,
	input wire pmp_pkg::master_cfg_t cfg,
	input wire logic irq_enable,
	input wire logic addr_load,
	input wire logic [15:0] addr_load_val,
	input wire logic req_read,
	input wire logic req_write,
	input wire logic [15:0] mst_wdata,
	input wire logic slv_cs,
	input wire logic slv_rd,
	input wire logic slv_wr,
	input wire logic [1:0] slv_addr,
	input wire logic sw_out_wr,
	input wire logic [1:0] sw_out_idx,
	input wire logic [7:0] sw_out_data,
	input wire logic sw_in_rd,
	input wire logic [1:0] sw_in_idx,
	input wire logic underflow_clr,
	input wire logic overflow_clr,
	input wire logic [7:0] port_data_in,
	output logic [7:0] port_data_pins,
	output logic port_data_oe,
	output logic [15:0] port_addr_pins,
	output logic [15:0] port_addr_oe,
	output logic read_strobe,
	output logic read_strobe_oe,
	output logic write_strobe,
	output logic write_strobe_oe,
	output logic byte_enable_strobe,
	output logic byte_enable_strobe_oe,
	output logic [15:0] mst_rdata,
	output logic [15:0] port_address_reg,
	output logic busy,
	output logic port_irq,
	output logic [3:0][7:0] in_bufs,
	output pmp_pkg::slave_status_t slv_status
);

	// ====================================================================
	// slave side
	logic slave_on;
	logic [7:0] slv_rd_data;
	logic slv_rd_active;

	assign slave_on = module_enable && (mode_sel == `MODE_SLAVE_ADDR);

	slave_buffers u_slave (
		.ref_clk(ref_clk),
		.rst(rst),
		.enable(slave_on),
		.slv_cs(slv_cs),
		.slv_rd(slv_rd),
		.slv_wr(slv_wr),
		.slv_addr(slv_addr),
		.slv_din(port_data_in),
		.sw_out_wr(sw_out_wr),
		.sw_out_idx(sw_out_idx),
		.sw_out_data(sw_out_data),
		.sw_in_rd(sw_in_rd),
		.sw_in_idx(sw_in_idx),
		.underflow_clr(underflow_clr),
		.overflow_clr(overflow_clr),
		.rd_data(slv_rd_data),
		.rd_active(slv_rd_active),
		.in_bufs(in_bufs),
		.status(slv_status)
	);

	// ====================================================================
	// master helpers
	pmp_pkg::mst_state_t s_reg, s_next;
	logic mst_on, waits_on, sel_one_cs, sel_two_cs, last_cycle, sel_active;
	logic [15:0] keep_mask, addr_stepped, addr_hi_mux;
	pmp_pkg::mstate_t first_st;
	logic [3:0] first_cnt;

	// polarity: set means active high
	function automatic logic pol_lvl(input logic act, input logic pol);
		pol_lvl = pol ? act : !act;
	endfunction

	assign mst_on = module_enable && mode_sel[1];
	assign waits_on = cfg.middle_wait_field != 4'h0;
	// chip-select function picks which top address pins are selects
	assign sel_two_cs = (cfg.chip_sel_func == `CSF_SEL_TWO)
		|| (cfg.chip_sel_func == `CSF_SEL_BOTH);
	assign sel_one_cs = cfg.chip_sel_func == `CSF_SEL_BOTH;
	assign keep_mask = {sel_two_cs, sel_one_cs, 14'h0000};

	// first data-phase state: setup only counts when the strobe wait is on
	assign first_st = (waits_on && cfg.begin_wait_field != 2'h0) ?
		pmp_pkg::M_SETUP : pmp_pkg::M_STROBE;
	assign first_cnt = (waits_on && cfg.begin_wait_field != 2'h0) ?
		{2'h0, cfg.begin_wait_field - 2'h1} : cfg.middle_wait_field;

	// address step leaves chip-select bits untouched
	assign addr_stepped = (cfg.addr_step_sel == `STEP_INC) ? s_reg.addr + 16'h0001 :
		(cfg.addr_step_sel == `STEP_DEC) ? s_reg.addr - 16'h0001 : s_reg.addr;
	// upper address byte for the data pins, select bits forced low
	assign addr_hi_mux = s_reg.addr & ~keep_mask;

	// last cycle of the current data-phase state's count (setup, strobe or hold)
	assign last_cycle = s_reg.cnt == 4'h0;

	// ====================================================================
	// master sequencer and pin next values
	always_comb begin
		s_next = s_reg;
		s_next.irq = 1'b0;
		unique case (s_reg.fsm)
			pmp_pkg::M_IDLE: begin
				if (addr_load) begin
					s_next.addr = addr_load_val;
				end
				// requests while busy never reach here
				if (mst_on && (req_read || req_write)) begin
					s_next.dir_rd = req_read;
					s_next.wdata = mst_wdata;
					s_next.hi = 1'b0;
					if (cfg.addr_mux_sel == `MUX_PART || cfg.addr_mux_sel == `MUX_FULL) begin
						s_next.fsm = pmp_pkg::M_ALO;
					end else begin
						s_next.fsm = first_st;
						s_next.cnt = first_cnt;
					end
				end
			end
			pmp_pkg::M_ALO: begin
				if (cfg.addr_mux_sel == `MUX_FULL) begin
					s_next.fsm = pmp_pkg::M_AHI;
				end else begin
					s_next.fsm = first_st;
					s_next.cnt = first_cnt;
				end
			end
			pmp_pkg::M_AHI: begin
				s_next.fsm = first_st;
				s_next.cnt = first_cnt;
			end
			pmp_pkg::M_SETUP: begin
				if (last_cycle) begin
					s_next.fsm = pmp_pkg::M_STROBE;
					s_next.cnt = cfg.middle_wait_field;
				end else begin
					s_next.cnt = s_reg.cnt - 4'h1;
				end
			end
			pmp_pkg::M_STROBE: begin
				if (last_cycle) begin
					// read data sampled on the strobe's final cycle
					if (s_reg.dir_rd && s_reg.hi) begin
						s_next.rdata[15:8] = port_data_in;
					end else if (s_reg.dir_rd) begin
						s_next.rdata[7:0] = port_data_in;
					end
					if (waits_on && cfg.end_wait_field != 2'h0) begin
						s_next.fsm = pmp_pkg::M_HOLD;
						s_next.cnt = {2'h0, cfg.end_wait_field - 2'h1};
					end else begin
						s_next.fsm = pmp_pkg::M_IDLE;
					end
				end else begin
					s_next.cnt = s_reg.cnt - 4'h1;
				end
			end
			pmp_pkg::M_HOLD: begin
				if (last_cycle) begin
					s_next.fsm = pmp_pkg::M_IDLE;
				end else begin
					s_next.cnt = s_reg.cnt - 4'h1;
				end
			end
			default: begin
				s_next.fsm = pmp_pkg::M_IDLE;
			end
		endcase
		// end of a byte: second byte of a wide word, else completion
		if (s_reg.fsm != pmp_pkg::M_IDLE && s_next.fsm == pmp_pkg::M_IDLE) begin
			if (cfg.wide_data_sel && !s_reg.hi) begin
				s_next.hi = 1'b1;
				s_next.fsm = first_st;
				s_next.cnt = first_cnt;
			end else begin
				s_next.irq = irq_enable;
				s_next.addr = (addr_stepped & ~keep_mask) | (s_reg.addr & keep_mask);
			end
		end
		// leaving master mode aborts a transfer
		if (!mst_on) begin
			s_next.fsm = pmp_pkg::M_IDLE;
		end
		s_next.busy = s_next.fsm != pmp_pkg::M_IDLE;

		// pins follow the next state so they leave straight from flops
		sel_active = s_next.busy;
		s_next.data_oe = 1'b0;
		s_next.data_out = s_next.hi ? s_next.wdata[15:8] : s_next.wdata[7:0];
		unique case (s_next.fsm)
			pmp_pkg::M_ALO: begin
				s_next.data_out = s_next.addr[7:0];
				s_next.data_oe = 1'b1;
			end
			pmp_pkg::M_AHI: begin
				s_next.data_out = addr_hi_mux[15:8];
				s_next.data_oe = 1'b1;
			end
			pmp_pkg::M_SETUP, pmp_pkg::M_STROBE, pmp_pkg::M_HOLD: begin
				s_next.data_oe = !s_next.dir_rd;
			end
			default: begin
				s_next.data_oe = 1'b0;
			end
		endcase
		// slave mode owns the data pins while a read strobe is active
		if (slave_on) begin
			s_next.data_out = slv_rd_data;
			s_next.data_oe = slv_rd_active;
		end
		// address pins, with latch strobes and chip selects overlaid
		s_next.addr_out = s_next.addr;
		if (cfg.addr_mux_sel != `MUX_DEMUX) begin
			s_next.addr_out[`PIN_LATCH_LOW] =
				pol_lvl(s_next.fsm == pmp_pkg::M_ALO, cfg.latch_pol);
		end
		if (cfg.addr_mux_sel == `MUX_FULL) begin
			s_next.addr_out[`PIN_LATCH_HIGH] =
				pol_lvl(s_next.fsm == pmp_pkg::M_AHI, cfg.latch_pol);
		end
		if (sel_one_cs) begin
			s_next.addr_out[`PIN_SEL_ONE] = pol_lvl(sel_active, cfg.sel_one_polarity);
		end
		if (sel_two_cs) begin
			s_next.addr_out[`PIN_SEL_TWO] = pol_lvl(sel_active, cfg.sel_two_polarity);
		end
		s_next.addr_oe = cfg.addr_pin_enables & {16{mst_on}};
		// read/write strobes, combined line and enable in mode 11
		if (mode_sel == `MODE_MSTR_ENB) begin
			s_next.rd_pin = pol_lvl(sel_active && s_next.dir_rd, cfg.read_pol);
			s_next.wr_pin = pol_lvl(s_next.fsm == pmp_pkg::M_STROBE, cfg.write_pol);
		end else begin
			s_next.rd_pin = pol_lvl(s_next.fsm == pmp_pkg::M_STROBE && s_next.dir_rd,
				cfg.read_pol);
			s_next.wr_pin = pol_lvl(s_next.fsm == pmp_pkg::M_STROBE && !s_next.dir_rd,
				cfg.write_pol);
		end
		s_next.be_pin = pol_lvl(s_next.hi && (s_next.fsm == pmp_pkg::M_SETUP
			|| s_next.fsm == pmp_pkg::M_STROBE || s_next.fsm == pmp_pkg::M_HOLD),
			cfg.byte_enable_pol);
		s_next.rd_oe = cfg.read_pin_en && mst_on;
		s_next.wr_oe = cfg.write_pin_en && mst_on;
		s_next.be_oe = cfg.byte_enable_pin_en && mst_on;
	end

	// state register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_reg <= '0;
			s_reg.fsm <= pmp_pkg::M_IDLE;
			s_reg.addr <= `RST_ADDR;
			s_reg.data_out <= `RST_BYTE;
		end else begin
			s_reg <= s_next;
		end
	end

	// ====================================================================
	// outputs straight from the state register
	assign port_data_pins = s_reg.data_out;
	assign port_data_oe = s_reg.data_oe;
	assign port_addr_pins = s_reg.addr_out;
	assign port_addr_oe = s_reg.addr_oe;
	assign read_strobe = s_reg.rd_pin;
	assign read_strobe_oe = s_reg.rd_oe;
	assign write_strobe = s_reg.wr_pin;
	assign write_strobe_oe = s_reg.wr_oe;
	assign byte_enable_strobe = s_reg.be_pin;
	assign byte_enable_strobe_oe = s_reg.be_oe;
	assign mst_rdata = s_reg.rdata;
	assign port_address_reg = s_reg.addr;
	assign busy = s_reg.busy;
	assign port_irq = s_reg.irq;

	// ====================================================================
	// checks
	a_busy_ignore: assert property (@(posedge ref_clk) disable iff (rst)
		s_reg.busy && req_write |=> $stable(s_reg.wdata))
		else $error("request taken while busy");
	a_no_master_off: assert property (@(posedge ref_clk) disable iff (rst)
		!mst_on |=> !busy)
		else $error("master ran outside master mode");
	a_full_addr_seq: assert property (@(posedge ref_clk) disable iff (rst)
		mst_on && !s_reg.busy && req_read && cfg.addr_mux_sel == `MUX_FULL ##1 mst_on
		|-> s_reg.fsm == pmp_pkg::M_ALO && port_data_pins == s_reg.addr[7:0]
		##1 (s_reg.fsm == pmp_pkg::M_AHI
		&& (port_data_pins[7:6] & {sel_two_cs, sel_one_cs}) == 2'b00) || !mst_on)
		else $error("full mux address phases wrong");
	a_sel_idle_level: assert property (@(posedge ref_clk) disable iff (rst)
		!busy && sel_two_cs && $stable(cfg) && $stable(busy)
		|-> port_addr_pins[`PIN_SEL_TWO] == !cfg.sel_two_polarity)
		else $error("idle chip select not inactive");
	a_wide_bytes: assert property (@(posedge ref_clk) disable iff (rst)
		mst_on && !s_reg.busy && req_write && cfg.wide_data_sel && !waits_on
		&& cfg.addr_mux_sel == `MUX_DEMUX ##1 $stable(cfg) && mst_on
		|-> port_data_pins == s_reg.wdata[7:0]
		##1 port_data_pins == s_reg.wdata[15:8] && byte_enable_strobe == cfg.byte_enable_pol)
		else $error("wide word byte order wrong");
	a_done_irq: assert property (@(posedge ref_clk) disable iff (rst)
		s_reg.busy && !s_next.busy && mst_on |=> port_irq == $past(irq_enable))
		else $error("completion interrupt wrong");
	a_strobe_len: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(s_reg.fsm == pmp_pkg::M_STROBE) && cfg.middle_wait_field == 4'h2
		&& mst_on ##1 $stable(cfg) && mst_on
		|-> s_reg.fsm == pmp_pkg::M_STROBE ##1 s_reg.fsm == pmp_pkg::M_STROBE || !mst_on)
		else $error("strobe shorter than middle wait");
	c_wide_write: cover property (@(posedge ref_clk) disable iff (rst)
		s_reg.hi && s_reg.fsm == pmp_pkg::M_STROBE && !s_reg.dir_rd);
	c_full_read: cover property (@(posedge ref_clk) disable iff (rst)
		s_reg.fsm == pmp_pkg::M_AHI ##[1:40] port_irq);
	c_wait_hold: cover property (@(posedge ref_clk) disable iff (rst)
		s_reg.fsm == pmp_pkg::M_HOLD);

endmodule // parallel_master_slave_port

`default_nettype wire

// ==== src/pmp_consts.svh ====
// constants for the parallel master/slave port: modes, encodings, pin slots, reset values
`ifndef PMP_CONSTS_SVH
`define PMP_CONSTS_SVH

// ====================================================================
// mode field encodings
`define MODE_SLAVE_ADDR 2'h1
`define MODE_MSTR_SEP 2'h2
`define MODE_MSTR_ENB 2'h3

// ====================================================================
// address multiplexing encodings
`define MUX_DEMUX 2'h0
`define MUX_PART 2'h1
`define MUX_FULL 2'h2

// ====================================================================
// address step encodings
`define STEP_INC 2'h1
`define STEP_DEC 2'h2

// ====================================================================
// chip-select function encodings
`define CSF_SEL_TWO 2'h1
`define CSF_SEL_BOTH 2'h2

// ====================================================================
// pin positions on the address pins
`define PIN_LATCH_LOW 0
`define PIN_LATCH_HIGH 1
`define PIN_SEL_ONE 14
`define PIN_SEL_TWO 15

// ====================================================================
// reset values
`define RST_OUT_EMPTY 4'hf
`define RST_IN_FULL 4'h0
`define RST_ADDR 16'h0000
`define RST_BYTE 8'h00

`endif

// ==== src/pmp_pkg.sv ====
// types shared by the parallel port modules
`default_nettype none
package pmp_pkg;

	// ====================================================================
	// master configuration carried as one bundle
	typedef struct packed {
		logic wide_data_sel;
		logic [1:0] addr_mux_sel;
		logic [1:0] addr_step_sel;
		logic [1:0] begin_wait_field;
		logic [3:0] middle_wait_field;
		logic [1:0] end_wait_field;
		logic [1:0] chip_sel_func;
		logic read_pol;
		logic write_pol;
		logic byte_enable_pol;
		logic latch_pol;
		logic sel_one_polarity;
		logic sel_two_polarity;
		logic byte_enable_pin_en;
		logic write_pin_en;
		logic read_pin_en;
		logic [15:0] addr_pin_enables;
	} master_cfg_t;

	// ====================================================================
	// slave buffer status
	typedef struct packed {
		logic [3:0] out_buf_empty_bit;
		logic all_out_empty_flag;
		logic [3:0] in_buf_full_bit;
		logic all_in_full_flag;
		logic underflow_flag;
		logic overflow_flag;
	} slave_status_t;

	// ====================================================================
	// master sequencer states
	typedef enum logic [5:0] {
		M_IDLE = 6'h01,
		M_ALO = 6'h02,
		M_AHI = 6'h04,
		M_SETUP = 6'h08,
		M_STROBE = 6'h10,
		M_HOLD = 6'h20
	} mstate_t;

	// slave side state
	typedef struct packed {
		logic [3:0][7:0] out_buf;
		logic [3:0][7:0] in_buf;
		slave_status_t stat;
		logic prev_rd;
		logic prev_wr;
		logic [7:0] rd_data;
		logic rd_active;
	} slv_state_t;

	// master side state, pins included
	typedef struct packed {
		mstate_t fsm;
		logic [3:0] cnt;
		logic hi;
		logic dir_rd;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic [15:0] addr;
		logic busy;
		logic irq;
		logic [7:0] data_out;
		logic data_oe;
		logic [15:0] addr_out;
		logic [15:0] addr_oe;
		logic rd_pin;
		logic rd_oe;
		logic wr_pin;
		logic wr_oe;
		logic be_pin;
		logic be_oe;
	} mst_state_t;

endpackage

`default_nettype wire

// ==== src/slave_buffers.sv ====
// addressable slave buffers: four output bytes, four input bytes, status flags
`timescale 1ns/1ps
`default_nettype none
`include "pmp_consts.svh"

module slave_buffers (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic enable,
	input wire logic slv_cs,
	input wire logic slv_rd,
	input wire logic slv_wr,
	input wire logic [1:0] slv_addr,
	input wire logic [7:0] slv_din,
	input wire logic sw_out_wr,
	input wire logic [1:0] sw_out_idx,
	input wire logic [7:0] sw_out_data,
	input wire logic sw_in_rd,
	input wire logic [1:0] sw_in_idx,
	input wire logic underflow_clr,
	input wire logic overflow_clr,
	output logic [7:0] rd_data,
	output logic rd_active,
	output logic [3:0][7:0] in_bufs,
	output pmp_pkg::slave_status_t status
);

	pmp_pkg::slv_state_t s_reg, s_next;
	logic rd_go, wr_go;

	// strobe start detection, strobes already in this clock domain
	assign rd_go = enable && slv_cs && slv_rd && !s_reg.prev_rd;
	assign wr_go = enable && slv_cs && slv_wr && !s_reg.prev_wr;

	// next state: clears first so a same-cycle set wins
	always_comb begin
		s_next = s_reg;
		s_next.prev_rd = enable && slv_cs && slv_rd;
		s_next.prev_wr = enable && slv_cs && slv_wr;
		s_next.rd_active = enable && slv_cs && slv_rd;
		s_next.rd_data = s_reg.out_buf[slv_addr];
		if (underflow_clr) begin
			s_next.stat.underflow_flag = 1'b0;
		end
		if (overflow_clr) begin
			s_next.stat.overflow_flag = 1'b0;
		end
		if (sw_out_wr) begin
			s_next.out_buf[sw_out_idx] = sw_out_data;
			s_next.stat.out_buf_empty_bit[sw_out_idx] = 1'b0;
		end
		if (sw_in_rd) begin
			s_next.stat.in_buf_full_bit[sw_in_idx] = 1'b0;
		end
		if (rd_go) begin
			if (s_reg.stat.out_buf_empty_bit[slv_addr]) begin
				s_next.stat.underflow_flag = 1'b1;
			end
			s_next.stat.out_buf_empty_bit[slv_addr] = 1'b1;
		end
		if (wr_go) begin
			if (s_reg.stat.in_buf_full_bit[slv_addr]) begin
				s_next.stat.overflow_flag = 1'b1;
			end else begin
				s_next.in_buf[slv_addr] = slv_din;
				s_next.stat.in_buf_full_bit[slv_addr] = 1'b1;
			end
		end
		s_next.stat.all_out_empty_flag = &s_next.stat.out_buf_empty_bit;
		s_next.stat.all_in_full_flag = &s_next.stat.in_buf_full_bit;
	end

	// state register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_reg <= '0;
			s_reg.stat.out_buf_empty_bit <= `RST_OUT_EMPTY;
			s_reg.stat.all_out_empty_flag <= 1'b1;
			s_reg.stat.in_buf_full_bit <= `RST_IN_FULL;
		end else begin
			s_reg <= s_next;
		end
	end

	assign rd_data = s_reg.rd_data;
	assign rd_active = s_reg.rd_active;
	assign in_bufs = s_reg.in_buf;
	assign status = s_reg.stat;

	// ====================================================================
	// checks
	a_read_drive: assert property (@(posedge ref_clk) disable iff (rst)
		enable && slv_cs && slv_rd |=> rd_active && rd_data == $past(s_reg.out_buf[slv_addr]))
		else $error("slave read byte wrong");
	a_under_raise: assert property (@(posedge ref_clk) disable iff (rst)
		rd_go && s_reg.stat.out_buf_empty_bit[slv_addr] |=> status.underflow_flag)
		else $error("underflow not raised");
	a_write_capture: assert property (@(posedge ref_clk) disable iff (rst)
		wr_go && !s_reg.stat.in_buf_full_bit[slv_addr]
		|=> in_bufs[$past(slv_addr)] == $past(slv_din) && status.in_buf_full_bit[$past(slv_addr)])
		else $error("slave write not captured");
	a_over_discard: assert property (@(posedge ref_clk) disable iff (rst)
		wr_go && s_reg.stat.in_buf_full_bit[slv_addr]
		|=> status.overflow_flag && $stable(in_bufs))
		else $error("overflow byte not discarded");
	c_slave_read: cover property (@(posedge ref_clk) disable iff (rst) rd_go);
	c_overflow: cover property (@(posedge ref_clk) disable iff (rst) $rose(status.overflow_flag));

endmodule // slave_buffers

`default_nettype wire

// ==== testbench/parallel_master_slave_port_bench.sv ====
// self-checking bench for the parallel master/slave port
`timescale 1ns/1ps
`default_nettype none
`include "pmp_consts.svh"

module parallel_master_slave_port_bench;
	logic ref_clk, rst, module_enable, irq_enable, addr_load, req_read, req_write, busy, port_irq;
	logic slv_cs, slv_rd, slv_wr, sw_out_wr, sw_in_rd, underflow_clr, overflow_clr, s0;
	logic [1:0] mode_sel, slv_addr, sw_out_idx, sw_in_idx;
	logic [7:0] sw_out_data, host_data, mem_data, port_data_in, port_data_pins, d0;
	logic [15:0] addr_load_val, mst_wdata, port_addr_pins, port_addr_oe, a0;
	logic [15:0] mst_rdata, port_address_reg;
	logic port_data_oe, read_strobe, read_strobe_oe, write_strobe, write_strobe_oe;
	logic byte_enable_strobe, byte_enable_strobe_oe;
	logic [3:0][7:0] in_bufs;
	pmp_pkg::master_cfg_t cfg;
	pmp_pkg::slave_status_t slv_status;
	int n_mismatch, num_checks;
	// data pins: host during slave cycles, memory otherwise
	assign port_data_in = slv_cs ? host_data : mem_data;
	parallel_master_slave_port dut (.ref_clk, .rst, .module_enable, .mode_sel, .cfg, .irq_enable,
		.addr_load, .addr_load_val, .req_read, .req_write, .mst_wdata, .slv_cs, .slv_rd, .slv_wr,
		.slv_addr, .sw_out_wr, .sw_out_idx, .sw_out_data, .sw_in_rd, .sw_in_idx, .underflow_clr,
		.overflow_clr, .port_data_in, .port_data_pins, .port_data_oe, .port_addr_pins,
		.port_addr_oe, .read_strobe, .read_strobe_oe, .write_strobe, .write_strobe_oe,
		.byte_enable_strobe, .byte_enable_strobe_oe, .mst_rdata, .port_address_reg, .busy,
		.port_irq, .in_bufs, .slv_status);
	port_memory_model mem (.ref_clk(ref_clk), .addr_pins(port_addr_pins),
		.read_active(read_strobe & read_strobe_oe), .rd_byte(mem_data));
	// ====================================================================
	// clock and common tasks
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic slv_write(input logic [1:0] a, input logic [7:0] d);
		{slv_cs, slv_wr, slv_addr, host_data} = {2'b11, a, d};
		@(negedge ref_clk);
		{slv_cs, slv_wr} = 2'b00;
		@(negedge ref_clk);
	endtask
	task automatic slv_read(input logic [1:0] a);
		{slv_cs, slv_rd, slv_addr} = {2'b11, a};
		repeat (3) @(negedge ref_clk);
		chk("read oe", port_data_oe, 1'b1);
		d0 = port_data_pins;
		{slv_cs, slv_rd} = 2'b00;
		repeat (3) @(negedge ref_clk);
	endtask
	// master transfer: count busy cycles, keep a snapshot of the first one
	task automatic mst_run(input logic rd, input logic [15:0] adr, input logic [7:0] cyc);
		int n;
		{addr_load, addr_load_val} = {1'b1, adr};
		@(negedge ref_clk);
		{addr_load, req_read, req_write} = {1'b0, rd, !rd};
		@(negedge ref_clk);
		{req_read, req_write} = 2'b00;
		n = 0;
		while (busy === 1'b1 && n < 40) begin
			if (n == 0)
				{d0, a0, s0} = {port_data_pins, port_addr_pins, write_strobe};
			if (n == 1)
				req_write = 1'b1;
			else if (n == 2)
				req_write = 1'b0;
			n++;
			@(negedge ref_clk);
		end
		if (n == 2)
			req_write = 1'b0;
		if (n == 40) begin
			n_mismatch++;
			wrap_up();
		end
		chk("busy cycles", n, cyc);
		chk("done irq", port_irq, 1'b1);
	endtask
	// ====================================================================
	// scenarios
	task automatic slave_writes();
		chk("reset status", slv_status, {4'hf, 1'b1, 4'h0, 3'h0});
		for (int i = 0; i < 4; i++) begin
			slv_write(i[1:0], 8'hc0 + 8'(i));
			chk("in buffer", in_bufs[i], 8'hc0 + 8'(i));
			chk("full bit", slv_status.in_buf_full_bit[i], 1'b1);
		end
		chk("all full", slv_status.all_in_full_flag, 1'b1);
		slv_write(2'h1, 8'hee);
		chk("overflow", slv_status.overflow_flag, 1'b1);
		chk("kept byte", in_bufs[1], 8'hc1);
	endtask
	task automatic slave_reads();
		{sw_out_wr, sw_out_idx, sw_out_data} = {1'b1, 2'h2, 8'ha5};
		@(negedge ref_clk);
		sw_out_wr = 1'b0;
		@(negedge ref_clk);
		chk("all empty low", slv_status.all_out_empty_flag, 1'b0);
		slv_read(2'h2);
		chk("read byte", d0, 8'ha5);
		chk("all empty", slv_status.all_out_empty_flag, 1'b1);
		chk("no underflow", slv_status.underflow_flag, 1'b0);
		slv_read(2'h2);
		chk("underflow", slv_status.underflow_flag, 1'b1);
	endtask
	task automatic master_plain();
		{req_write, mode_sel} = {1'b1, `MODE_SLAVE_ADDR};
		@(negedge ref_clk);
		req_write = 1'b0;
		@(negedge ref_clk);
		chk("no master in slave", busy, 1'b0);
		chk("pins released", port_addr_oe, 16'h0000);
		{mode_sel, mst_wdata} = {`MODE_MSTR_SEP, 16'h0037};
		mst_run(1'b0, 16'h0120, 8'h01);
		chk("data pins", d0, 8'h37);
		chk("addr pins", a0, 16'h0120);
		chk("write strobe", s0, 1'b1);
		chk("step up", port_address_reg, 16'h0121);
		chk("pin enables", {port_addr_oe, read_strobe_oe, write_strobe_oe, byte_enable_strobe_oe},
			{16'hffff, 3'h7});
	endtask
	task automatic master_waits();
		{cfg.begin_wait_field, cfg.middle_wait_field, cfg.end_wait_field} = {2'h1, 4'h2, 2'h1};
		mst_run(1'b1, 16'h0033, 8'h05);
		chk("read data", mst_rdata[7:0], 8'h69);
		{cfg.begin_wait_field, cfg.middle_wait_field, cfg.end_wait_field} = {2'h3, 4'h0, 2'h3};
		mst_run(1'b0, 16'h0033, 8'h01);
	endtask
	task automatic master_mux();
		{mode_sel, cfg.addr_mux_sel, cfg.addr_step_sel} = {`MODE_MSTR_ENB, `MUX_PART, `STEP_DEC};
		mst_run(1'b0, 16'h0244, 8'h02);
		chk("low addr on data", d0, 8'h44);
		chk("enable off in address", s0, 1'b0);
		chk("latch low", a0[`PIN_LATCH_LOW], 1'b1);
		chk("step down", port_address_reg, 16'h0243);
		{mode_sel, cfg.addr_mux_sel} = {`MODE_MSTR_SEP, `MUX_FULL};
		cfg.chip_sel_func = `CSF_SEL_BOTH;
		mst_run(1'b1, 16'hc000, 8'h03);
		chk("full mux low", d0, 8'h00);
		chk("full mux read", mst_rdata[7:0], 8'h5a);
		chk("selects busy", a0[15:14], 2'b11);
		chk("selects idle", port_addr_pins[15:14], 2'b00);
		chk("selects kept", port_address_reg, 16'hffff);
		{cfg.addr_mux_sel, cfg.wide_data_sel} = {`MUX_DEMUX, 1'b1};
		mst_run(1'b0, 16'h0244, 8'h02);
	endtask
	// ====================================================================
	// main sequence
	initial begin
		{rst, module_enable, irq_enable} = 3'h7;
		{addr_load, req_read, req_write, slv_cs, slv_rd, slv_wr, sw_out_wr, sw_in_rd} = 8'h00;
		{underflow_clr, overflow_clr, mode_sel, slv_addr, sw_out_idx, sw_in_idx} = 10'h000;
		{sw_out_data, host_data, addr_load_val, mst_wdata} = 48'h0000_0000_0000;
		cfg = '1;
		{cfg.wide_data_sel, cfg.addr_mux_sel, cfg.chip_sel_func} = 5'h00;
		{cfg.begin_wait_field, cfg.middle_wait_field, cfg.end_wait_field} = 8'h00;
		cfg.addr_step_sel = `STEP_INC;
		{n_mismatch, num_checks} = {32'h0, 32'h0};
		mode_sel = `MODE_SLAVE_ADDR;
		repeat (12) @(negedge ref_clk);
		rst = 1'b0;
		@(negedge ref_clk);
		slave_writes();
		slave_reads();
		master_plain();
		master_waits();
		master_mux();
		wrap_up();
	end
endmodule // parallel_master_slave_port_bench
`default_nettype wire

// ==== testbench/port_memory_model.sv ====
// behavioural parallel memory on the master side of the port
`timescale 1ns/1ps
`default_nettype none

module port_memory_model (
	input wire logic ref_clk,
	input wire logic [15:0] addr_pins,
	input wire logic read_active,
	output logic [7:0] rd_byte
);
	logic [7:0] last_reg;
	initial last_reg = 8'h00;
	// released bus toggles every cycle so stale data never looks valid
	always @(posedge ref_clk) begin
		last_reg <= ~rd_byte;
	end
	// answer with an address pattern while the read strobe is active
	assign rd_byte = read_active ? (addr_pins[7:0] ^ 8'h5a) : last_reg;
endmodule // port_memory_model
`default_nettype wire
